// File: hdl/pdtx_framer.sv
// pdtx_framer: token port register, transmit and receive byte fifo_token_port,
// and the transmit token sequencer that feeds the 4b5b line coder.
// assumes: register port and line coder share i_mclk; the cc activity
// level comes from the analog front end and is synchronised here.
// How it works
// R1 - port writes push one token byte
// R2 - port reads pop the receive fifo
// R3 - software zeroes reserved transmit bits
// R4 - one token finishes before the next
// R5 - token codes mapped to line symbols here
// R6 - 101x_xxx1 write launches, never queued
// R7 - software uses exactly A1h to launch
// R8 - software loads packet before launching
// R9 - sync tokens send sync symbols
// R10 - reset tokens send reset symbols
// R11 - packed token carries following byte count
// R12 - software keeps count in 2..30
// R13 - low nibble first, then high nibble
// R14 - crc token sends hardware crc
// R15 - eop token sends end-of-packet
// R16 - driver-off token drops the driver
// R17 - first receive byte holds packet type
// R18 - receive fifo holds eighty bytes
// R19 - busy line at launch: collision, no send
// R20 - undefined tokens discarded silently
// R21 - writes into full fifo dropped
`timescale 1ns/1ps
module pdtx_framer
    import pdtx_pkg::*;
#(
    parameter int TX_DEPTH = pdtx_pkg::TX_DEPTH_DEF,
    parameter int RX_DEPTH = pdtx_pkg::RX_DEPTH_DEF
)
(
    // clock, reset, enable
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    // register port
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // transmit control
    input wire logic i_tx_start,
    input wire logic i_cc_active,
    output logic o_collision,
    output logic o_drv_en,
    // symbols to the line coder
    output logic o_sym_valid,
    output pdtx_pkg::pdtx_sym_t o_sym_code,
    output logic [3:0] o_sym_nib,
    input wire logic i_sym_ready,
    // receive bytes from the packet receiver
    input wire logic i_rx_push,
    input wire logic i_rx_is_sop,
    input wire logic [1:0] i_rx_sop_kind,
    input wire logic [7:0] i_rx_data,
    // fifo status
    output logic o_tx_full,
    output logic o_tx_empty,
    output logic o_rx_full,
    output logic o_rx_empty
);
    import pdtx_pkg::*;

    localparam int TAW = $clog2(TX_DEPTH);
    localparam int RAW = $clog2(RX_DEPTH);
    localparam int TCW = $clog2(TX_DEPTH + 1);
    localparam int RCW = $clog2(RX_DEPTH + 1);
    localparam logic [TCW-1:0] TX_FULL_CNT = TCW'(TX_DEPTH);
    localparam logic [RCW-1:0] RX_FULL_CNT = RCW'(RX_DEPTH);

    // depths below two leave no room for a packed token and its data
    if (TX_DEPTH < 2 || RX_DEPTH < 2)
    begin : g_bad_depth
        $error("fifo depths must be at least two");
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // wrap a fifo pointer at its depth
    function automatic int ptr_next(input int p, input int depth);
        ptr_next = (p == depth - 1) ? 0 : p + 1;
    endfunction

    // crc-32, reflected, four data bits lsb first
    function automatic logic [31:0] crc_nib(input logic [31:0] c,
                                            input logic [3:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 4; i++)
        begin
            r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY_REFL) : (r >> 1);
        end
        crc_nib = r;
    endfunction

    // ------------------------------------------------------------
    // storage and state
    // ------------------------------------------------------------
    logic [7:0] tx_mem [TX_DEPTH]; // transmit token bytes
    logic [7:0] rx_mem [RX_DEPTH]; // receive bytes
    logic [TAW-1:0] tx_rd; // transmit head
    logic [TAW-1:0] tx_wr; // transmit tail
    logic [TCW-1:0] tx_cnt; // transmit fill
    logic [RAW-1:0] rx_rd; // receive head
    logic [RAW-1:0] rx_wr; // receive tail
    logic [RCW-1:0] rx_cnt; // receive fill
    pdtx_state_t state; // sequencer state
    logic [PACK_CNT_W-1:0] pack_left; // packed bytes still to pop
    logic [7:0] pack_byte; // byte being sent as nibbles
    logic [31:0] crc; // running crc of sent nibbles
    logic [2:0] crc_idx; // crc nibble being sent
    logic launch_pend; // launch waiting for idle
    logic cc_meta; // synchroniser, first stage
    logic cc_busy; // synchronised line activity

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic port_hit;
    logic inline_transmit_launch;
    logic tx_push;
    logic tx_pop;
    logic rx_pop;
    logic rx_push;
    logic [7:0] tx_head;
    logic [7:0] rx_byte;
    logic [31:0] crc_out;
    logic sym_take;

    assign port_hit = (i_reg_addr == FIFO_TOKEN_PORT_ADDR);
    assign inline_transmit_launch = i_reg_wr && port_hit &&
        ((i_reg_wdata & LAUNCH_MASK) == LAUNCH_MATCH); // R6
    assign o_tx_full = (tx_cnt == TX_FULL_CNT);
    assign o_tx_empty = (tx_cnt == '0);
    assign o_rx_full = (rx_cnt == RX_FULL_CNT);
    assign o_rx_empty = (rx_cnt == '0);
    // launch byte is a command; a full fifo drops the write
    assign tx_push = i_ce && i_reg_wr && port_hit &&
        !inline_transmit_launch && !o_tx_full; // R1 R21
    // only fetch and pack states consume, one byte at a time
    assign tx_pop = i_ce && !o_tx_empty &&
        (state == S_FETCH || state == S_PACK); // R4
    assign rx_pop = i_ce && i_reg_rd && port_hit && !o_rx_empty; // R2
    // received bytes beyond capacity are lost
    assign rx_push = i_ce && i_rx_push && !o_rx_full; // R18
    assign tx_head = tx_mem[tx_rd];
    assign crc_out = ~crc;
    assign sym_take = o_sym_valid && i_sym_ready;

    // start-of-packet byte: type in the top bits, rest zero
    always_comb
    begin
        rx_byte = i_rx_data;
        if (i_rx_is_sop)
        begin
            case (i_rx_sop_kind) // R17
                SOP_KIND_PRIME: rx_byte = {RX_TYPE_PRIME, 5'h00};
                SOP_KIND_DPRIME: rx_byte = {RX_TYPE_DPRIME, 5'h00};
                default: rx_byte = {RX_TYPE_PLAIN, 5'h00};
            endcase
        end
    end

    // ------------------------------------------------------------
    // transmit fifo
    // ------------------------------------------------------------
    // memory has no reset; only pointers define content
    always_ff @(posedge i_mclk)
    begin
        if (tx_push)
        begin
            tx_mem[tx_wr] <= i_reg_wdata;
        end
    end

    // pointers and fill count
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            tx_rd <= '0;
            tx_wr <= '0;
            tx_cnt <= '0;
        end
        else
        begin
            if (tx_push)
            begin
                tx_wr <= TAW'(ptr_next(int'(tx_wr), TX_DEPTH));
            end
            if (tx_pop)
            begin
                tx_rd <= TAW'(ptr_next(int'(tx_rd), TX_DEPTH));
            end
            if (tx_push && !tx_pop)
            begin
                tx_cnt <= tx_cnt + 1'b1;
            end
            else if (tx_pop && !tx_push)
            begin
                tx_cnt <= tx_cnt - 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // receive fifo and port read data
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk)
    begin
        if (rx_push)
        begin
            rx_mem[rx_wr] <= rx_byte;
        end
    end

    // reads of an empty fifo return zero and move nothing
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            rx_rd <= '0;
            rx_wr <= '0;
            rx_cnt <= '0;
            o_reg_rdata <= FIFO_TOKEN_PORT_RST;
        end
        else
        begin
            if (rx_push)
            begin
                rx_wr <= RAW'(ptr_next(int'(rx_wr), RX_DEPTH));
            end
            if (rx_pop)
            begin
                rx_rd <= RAW'(ptr_next(int'(rx_rd), RX_DEPTH));
                o_reg_rdata <= rx_mem[rx_rd]; // R2
            end
            else if (i_ce && i_reg_rd)
            begin
                o_reg_rdata <= FIFO_TOKEN_PORT_RST;
            end
            if (rx_push && !rx_pop)
            begin
                rx_cnt <= rx_cnt + 1'b1;
            end
            else if (rx_pop && !rx_push)
            begin
                rx_cnt <= rx_cnt - 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // launch request and line activity
    // ------------------------------------------------------------
    // a new launch wins over its consumption in the same cycle
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            launch_pend <= 1'b0;
            cc_meta <= 1'b0;
            cc_busy <= 1'b0;
        end
        else if (i_ce)
        begin
            cc_meta <= i_cc_active;
            cc_busy <= cc_meta;
            launch_pend <= (launch_pend && state != S_IDLE) ||
                i_tx_start || inline_transmit_launch; // R6
        end
    end

    // ------------------------------------------------------------
    // token sequencer
    // ------------------------------------------------------------
    // symbol outputs hold until the line coder takes them
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            state <= S_IDLE;
            o_sym_valid <= 1'b0;
            o_sym_code <= SYM_DATA;
            o_sym_nib <= 4'h0;
            o_drv_en <= 1'b0;
            o_collision <= 1'b0;
            pack_left <= '0;
            pack_byte <= 8'h00;
            crc <= CRC_INIT;
            crc_idx <= 3'h0;
        end
        else if (i_ce)
        begin
            o_collision <= 1'b0;
            case (state)
                S_IDLE:
                begin
                    if (launch_pend && cc_busy)
                    begin
                        o_collision <= 1'b1; // R19
                    end
                    else if (launch_pend)
                    begin
                        o_drv_en <= 1'b1;
                        state <= S_FETCH;
                    end
                end
                S_FETCH:
                begin
                    if (!o_tx_empty)
                    begin
                        o_sym_nib <= 4'h0;
                        // token to symbol mapping lives here
                        if (tx_head == SYNC_ONE_TOKEN ||
                            tx_head == SYNC_TWO_TOKEN ||
                            tx_head == SYNC_THREE_TOKEN)
                        begin
                            o_sym_valid <= 1'b1; // R9 R5
                            o_sym_code <= (tx_head == SYNC_ONE_TOKEN) ?
                                SYM_SYNC1 : (tx_head == SYNC_TWO_TOKEN) ?
                                SYM_SYNC2 : SYM_SYNC3;
                            crc <= CRC_INIT; // new packet, fresh crc
                            state <= S_EMIT;
                        end
                        else if (tx_head == RST_ONE_TOKEN ||
                                 tx_head == RST_TWO_TOKEN)
                        begin
                            o_sym_valid <= 1'b1; // R10
                            o_sym_code <= (tx_head == RST_ONE_TOKEN) ?
                                SYM_RST1 : SYM_RST2;
                            state <= S_EMIT;
                        end
                        else if (tx_head == EOP_TOKEN)
                        begin
                            o_sym_valid <= 1'b1; // R15
                            o_sym_code <= SYM_EOP;
                            state <= S_EMIT;
                        end
                        else if (tx_head == CRC_INSERT_TOKEN)
                        begin
                            o_sym_valid <= 1'b1; // R14
                            o_sym_code <= SYM_DATA;
                            o_sym_nib <= crc_out[3:0];
                            crc_idx <= 3'h0;
                            state <= S_CRC;
                        end
                        else if (tx_head == DRIVER_DISABLE_TOKEN)
                        begin
                            o_drv_en <= 1'b0; // R16
                            state <= S_IDLE;
                        end
                        else if (tx_head[7:PACK_TAG_LSB] ==
                                 PACKED_DATA_TOKEN)
                        begin
                            // a zero count sends nothing
                            pack_left <= tx_head[PACK_CNT_W-1:0]; // R11
                            if (tx_head[PACK_CNT_W-1:0] != '0)
                            begin
                                state <= S_PACK;
                            end
                        end
                        // any other code was popped and is dropped: R20
                    end
                end
                S_EMIT:
                begin
                    if (sym_take)
                    begin
                        o_sym_valid <= 1'b0;
                        state <= S_FETCH;
                    end
                end
                S_PACK:
                begin
                    if (!o_tx_empty)
                    begin
                        pack_byte <= tx_head;
                        pack_left <= pack_left - 1'b1;
                        o_sym_valid <= 1'b1;
                        o_sym_code <= SYM_DATA;
                        o_sym_nib <= tx_head[3:0]; // R13
                        state <= S_LO;
                    end
                end
                S_LO:
                begin
                    if (sym_take)
                    begin
                        crc <= crc_nib(crc, pack_byte[3:0]);
                        o_sym_nib <= pack_byte[7:4]; // R13
                        state <= S_HI;
                    end
                end
                S_HI:
                begin
                    if (sym_take)
                    begin
                        crc <= crc_nib(crc, pack_byte[7:4]);
                        o_sym_valid <= 1'b0;
                        state <= (pack_left == '0) ? S_FETCH : S_PACK;
                    end
                end
                S_CRC:
                begin
                    // crc is frozen while its nibbles go out
                    if (sym_take && crc_idx == CRC_LAST_NIB)
                    begin
                        o_sym_valid <= 1'b0;
                        state <= S_FETCH;
                    end
                    else if (sym_take)
                    begin
                        crc_idx <= crc_idx + 1'b1;
                        o_sym_nib <= crc_out[4*(crc_idx+3'h1) +: 4]; // R14
                    end
                end
                default:
                begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_push;
        @(posedge i_mclk) disable iff (i_sys_rst)
        tx_push && !tx_pop |=> tx_cnt == $past(tx_cnt) + 1'b1;
    endproperty
    a_push: assert property (p_push) // R1
        else $error("token write not queued");

    property p_launch;
        @(posedge i_mclk) disable iff (i_sys_rst)
        i_ce && inline_transmit_launch && !tx_pop |=>
            tx_cnt == $past(tx_cnt) && launch_pend;
    endproperty
    a_launch: assert property (p_launch) // R6
        else $error("launch byte queued or lost");

    property p_full;
        @(posedge i_mclk) disable iff (i_sys_rst)
        o_tx_full && !tx_pop |=> o_tx_full;
    endproperty
    a_full: assert property (p_full) // R21
        else $error("full flag fell without a pop");

    property p_rdpop;
        @(posedge i_mclk) disable iff (i_sys_rst)
        rx_pop && !rx_push |=> rx_cnt == $past(rx_cnt) - 1'b1;
    endproperty
    a_rdpop: assert property (p_rdpop) // R2
        else $error("port read did not pop");

    property p_sync;
        @(posedge i_mclk) disable iff (i_sys_rst)
        tx_pop && state == S_FETCH && tx_head == SYNC_THREE_TOKEN |=>
            o_sym_valid && o_sym_code == SYM_SYNC3;
    endproperty
    a_sync: assert property (p_sync) // R9
        else $error("sync token gave wrong symbol");

    property p_rst;
        @(posedge i_mclk) disable iff (i_sys_rst)
        tx_pop && state == S_FETCH && tx_head == RST_TWO_TOKEN |=>
            o_sym_valid && o_sym_code == SYM_RST2;
    endproperty
    a_rst: assert property (p_rst) // R10
        else $error("reset token gave wrong symbol");

    property p_off;
        @(posedge i_mclk) disable iff (i_sys_rst)
        tx_pop && state == S_FETCH && tx_head == DRIVER_DISABLE_TOKEN
            |=> !o_drv_en && state == S_IDLE;
    endproperty
    a_off: assert property (p_off) // R16
        else $error("driver left on");

    property p_nib;
        @(posedge i_mclk) disable iff (i_sys_rst)
        i_ce && state == S_LO && sym_take |=>
            o_sym_nib == $past(pack_byte[7:4]) && state == S_HI;
    endproperty
    a_nib: assert property (p_nib) // R13
        else $error("high nibble not after low");

    property p_coll;
        @(posedge i_mclk) disable iff (i_sys_rst)
        i_ce && state == S_IDLE && launch_pend && cc_busy |=>
            o_collision && !o_drv_en;
    endproperty
    a_coll: assert property (p_coll) // R19
        else $error("sent onto a busy line");

    property p_rxcap;
        @(posedge i_mclk) disable iff (i_sys_rst)
        rx_cnt <= RX_FULL_CNT;
    endproperty
    a_rxcap: assert property (p_rxcap) // R18
        else $error("receive fill beyond capacity");
endmodule

// File: hdl/pdtx_pkg.sv
// pdtx_pkg: constants and types of the token framer.
// assumes: one clock domain, the register port runs on that clock.
package pdtx_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] FIFO_TOKEN_PORT_ADDR = 8'h43; // token port
    localparam logic [7:0] FIFO_TOKEN_PORT_RST = 8'h00; // read reset
    // inline launch: pattern 101x_xxx1
    localparam logic [7:0] LAUNCH_MASK = 8'hE1;
    localparam logic [7:0] LAUNCH_MATCH = 8'hA1;
    // ------------------------------------------------------------
    // transmit token codes
    // ------------------------------------------------------------
    localparam logic [7:0] SYNC_ONE_TOKEN = 8'h12;
    localparam logic [7:0] SYNC_TWO_TOKEN = 8'h13;
    localparam logic [7:0] SYNC_THREE_TOKEN = 8'h1B;
    localparam logic [7:0] RST_ONE_TOKEN = 8'h15;
    localparam logic [7:0] RST_TWO_TOKEN = 8'h16;
    localparam logic [7:0] EOP_TOKEN = 8'h14;
    localparam logic [7:0] CRC_INSERT_TOKEN = 8'hFF;
    localparam logic [7:0] DRIVER_DISABLE_TOKEN = 8'hFE;
    localparam logic [2:0] PACKED_DATA_TOKEN = 3'h4; // upper three bits
    localparam int PACK_TAG_LSB = 5; // tag field starts here
    localparam int PACK_CNT_W = 5; // count field width
    // ------------------------------------------------------------
    // receive start-of-packet type codes, upper three bits
    // ------------------------------------------------------------
    localparam logic [2:0] RX_TYPE_PLAIN = 3'h7;
    localparam logic [2:0] RX_TYPE_PRIME = 3'h6;
    localparam logic [2:0] RX_TYPE_DPRIME = 3'h5;
    localparam logic [1:0] SOP_KIND_PLAIN = 2'h0;
    localparam logic [1:0] SOP_KIND_PRIME = 2'h1;
    localparam logic [1:0] SOP_KIND_DPRIME = 2'h2;
    // ------------------------------------------------------------
    // depths and crc
    // ------------------------------------------------------------
    localparam int RX_DEPTH_DEF = 80; // receive bytes
    localparam int TX_DEPTH_DEF = 48; // transmit bytes
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_POLY_REFL = 32'hEDB88320;
    localparam logic [2:0] CRC_LAST_NIB = 3'h7;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_FETCH = 7'h02,
        S_EMIT = 7'h04,
        S_PACK = 7'h08,
        S_LO = 7'h10,
        S_HI = 7'h20,
        S_CRC = 7'h40
    } pdtx_state_t;
    typedef enum logic [2:0] {
        SYM_DATA = 3'h0,
        SYM_SYNC1 = 3'h1,
        SYM_SYNC2 = 3'h2,
        SYM_SYNC3 = 3'h3,
        SYM_RST1 = 3'h4,
        SYM_RST2 = 3'h5,
        SYM_EOP = 3'h6
    } pdtx_sym_t;
endpackage

// File: test/pdtx_coder_model.sv
// pdtx_coder_model: line coder stand-in that takes symbols.
// assumes: shares i_mclk; slow mode stalls every other cycle.
`timescale 1ns/1ps
module pdtx_coder_model
    import pdtx_pkg::*;
(
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // symbol stream
    input wire logic i_slow,
    input wire logic i_sym_valid,
    input wire pdtx_pkg::pdtx_sym_t i_sym_code,
    input wire logic [3:0] i_sym_nib,
    output logic o_sym_ready
);
    logic [6:0] taken_q[$]; // code and nibble of each symbol taken
    // slow mode toggles ready so every symbol must be held
    always_ff @(posedge i_mclk or posedge i_sys_rst)
        if (i_sys_rst)
            o_sym_ready <= 1'h0;
        else
            o_sym_ready <= i_slow ? ~o_sym_ready : 1'h1;
    // record on each edge where valid meets ready
    always @(posedge i_mclk)
        if (!i_sys_rst && i_sym_valid && o_sym_ready)
            taken_q.push_back({i_sym_code, i_sym_nib});
endmodule

// File: test/pdtx_framer_tb.sv
// pdtx_framer_tb: self-checking bench for the token framer.
// assumes: coder model file compiled first; one 200 MHz clock.
`timescale 1ns/1ps
module pdtx_framer_tb;
    import pdtx_pkg::*;
    logic i_mclk = 1'h0, i_sys_rst = 1'h1, i_ce = 1'h1, i_slow = 1'h1;
    logic i_reg_wr = 1'h0, i_reg_rd = 1'h0, i_tx_start = 1'h0;
    logic i_cc_active = 1'h0, i_rx_push = 1'h0, i_rx_is_sop = 1'h0;
    logic [7:0] i_reg_addr = 8'h43, i_reg_wdata = 8'h00, o_reg_rdata;
    logic [7:0] i_rx_data = 8'h00;
    logic [1:0] i_rx_sop_kind = 2'h0;
    logic o_collision, o_drv_en, o_sym_valid, i_sym_ready;
    logic o_tx_full, o_tx_empty, o_rx_full, o_rx_empty;
    logic [3:0] o_sym_nib;
    pdtx_sym_t o_sym_code;
    int err_total = 0, total_checks = 0;
    pdtx_framer i_dut (.*);
    pdtx_coder_model i_coder (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_slow(i_slow), .i_sym_valid(o_sym_valid),
        .i_sym_code(o_sym_code), .i_sym_nib(o_sym_nib),
        .o_sym_ready(i_sym_ready));
    initial forever #2.5 i_mclk = ~i_mclk;
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(string n, logic [7:0] e, logic [7:0] s);
        total_checks++;
        if (s !== e)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(logic [7:0] b);
        @(negedge i_mclk) i_reg_wr = 1'h1;
        i_reg_wdata = b;
        @(negedge i_mclk) i_reg_wr = 1'h0;
    endtask
    // read data lands on the clock edge that samples the read
    task automatic rd(output logic [7:0] b);
        @(negedge i_mclk) i_reg_rd = 1'h1;
        @(negedge i_mclk) i_reg_rd = 1'h0;
        b = o_reg_rdata;
    endtask
    task automatic push(logic s, logic [1:0] kd, logic [7:0] d);
        @(negedge i_mclk) i_rx_push = 1'h1;
        i_rx_is_sop = s;
        i_rx_sop_kind = kd;
        i_rx_data = d;
        @(negedge i_mclk) i_rx_push = 1'h0;
    endtask
    // a hang here ends the run as a failure
    task automatic wait_drv(logic v, int n);
        for (int k = 0; k < n && o_drv_en !== v; k++)
            @(negedge i_mclk);
        if (o_drv_en !== v)
        begin
            chk("drv", {7'h0, v}, {7'h0, o_drv_en});
            final_report();
        end
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_rx();
        logic [7:0] b;
        logic [7:0] tp [3] = '{8'hE0, 8'hC0, 8'hA0};
        for (int k = 0; k < 3; k++)
        begin
            push(1'h1, k[1:0], 8'h00);
            push(1'h0, 2'h0, 8'h5A);
            rd(b);
            chk("rx type", tp[k], b & 8'hE0);
            rd(b);
            chk("rx data", 8'h5A, b);
        end
        rd(b);
        chk("rx empty read", 8'h00, b);
        $display("test rx done");
    endtask
    // whole packet, slow coder, undefined token in the middle
    task automatic test_tx();
        logic [7:0] tk [12] = '{8'h12, 8'h13, 8'h1B, 8'h15, 8'h16,
            8'h00, 8'h82, 8'h34, 8'h56, 8'hFF, 8'h14, 8'hFE};
        logic [6:0] ex [9] = '{7'h10, 7'h20, 7'h30, 7'h40, 7'h50,
            7'h04, 7'h03, 7'h06, 7'h05};
        logic [31:0] c = CRC_INIT;
        logic [15:0] d = 16'h5634; // packed bytes, first byte low
        // expected crc: packed bits lsb first
        for (int i = 0; i < 16; i++)
            c = (c[0] ^ d[i]) ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
        c = ~c;
        foreach (tk[k])
            wr(tk[k]);
        chk("tx empty", 8'h00, {7'h0, o_tx_empty});
        wr(8'hA1);
        wait_drv(1'h1, 50);
        wait_drv(1'h0, 3000);
        chk("symbols", 8'h12, 8'(i_coder.taken_q.size()));
        foreach (ex[k])
            chk("symbol", 8'(ex[k]), 8'(i_coder.taken_q[k]));
        for (int k = 9; k < 17; k++)
        begin
            chk("crc kind", 8'h00, 8'(i_coder.taken_q[k][6:4]));
            chk("crc", 8'(c[3:0]), 8'(i_coder.taken_q[k][3:0]));
            c = c >> 4;
        end
        chk("eop", 8'h06, 8'(i_coder.taken_q[17][6:4]));
        chk("tx drained", 8'h01, {7'h0, o_tx_empty});
        $display("test tx done");
    endtask
    // busy line: refused with a flag and dropped; a new start sends
    task automatic test_coll();
        int k;
        i_slow = 1'h0;
        wr(8'hFE);
        @(negedge i_mclk) i_cc_active = 1'h1;
        repeat (4) @(negedge i_mclk);
        i_tx_start = 1'h1;
        @(negedge i_mclk) i_tx_start = 1'h0;
        for (k = 0; k < 20 && o_collision !== 1'h1; k++)
            @(negedge i_mclk);
        chk("collision", 8'h01, {7'h0, o_collision});
        chk("driver off", 8'h00, {7'h0, o_drv_en});
        chk("tx kept", 8'h00, {7'h0, o_tx_empty});
        i_cc_active = 1'h0;
        repeat (4) @(negedge i_mclk);
        chk("no retry", 8'h00, {7'h0, o_drv_en});
        i_tx_start = 1'h1;
        @(negedge i_mclk) i_tx_start = 1'h0;
        wait_drv(1'h1, 50);
        wait_drv(1'h0, 50);
        $display("test collision done");
    endtask
    // overflow bytes of either fifo are lost
    task automatic test_full();
        logic [7:0] b;
        i_ce = 1'h0;
        wr(8'h14);
        i_ce = 1'h1;
        chk("ce hold", 8'h01, {7'h0, o_tx_empty});
        repeat (TX_DEPTH_DEF + 1) wr(8'h14);
        chk("tx full", 8'h01, {7'h0, o_tx_full});
        wr(8'hA1);
        wait_drv(1'h1, 50);
        repeat (4) @(negedge i_mclk);
        wr(8'hFE);
        wait_drv(1'h0, 500);
        chk("eops", 8'(TX_DEPTH_DEF + 18), 8'(i_coder.taken_q.size()));
        for (int k = 0; k <= RX_DEPTH_DEF; k++)
            push(1'h0, 2'h0, 8'(k));
        chk("rx full", 8'h01, {7'h0, o_rx_full});
        for (int k = 0; k < RX_DEPTH_DEF; k++)
        begin
            rd(b);
            chk("rx byte", 8'(k), b);
        end
        chk("rx empty", 8'h01, {7'h0, o_rx_empty});
        $display("test full done");
    endtask
    initial
    begin
        repeat (16) @(negedge i_mclk);
        i_sys_rst = 1'h0;
        chk("rdata reset", 8'h00, o_reg_rdata);
        chk("tx empty reset", 8'h01, {7'h0, o_tx_empty});
        test_rx();
        test_tx();
        test_coll();
        test_full();
        final_report();
    end
endmodule
